// File: logic/vr_startup_protect.sv
// start-up, phase select, fault latch and current balance of a multi-phase controller
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - start only with reset released, chip enable high and driver supply detected
// - sample phase 3, 4 and 5 drive pins as reset is released
// - pulled-high phase 3 pin picks two phases, phase 5 pin picks four
// - while not ready all phase drive pins float
// - when ready, begin a soft-start ramp of the reference
// - reference ramps piecewise linearly, trailing the internal ramp by a fixed drop
// - release power good 1 to 2 ms after output reaches target
// - trip over-voltage when output exceeds reference by 170 mV
// - on over-voltage drive all phases low and latch the fault
// - only dropping reset, enable or driver detect clears the fault latch
// - target changes in operation move the reference along the ramp
// - one shared sense channel samples each active phase in turn per cycle
// - sum the held phase currents and take their average
// - trim each phase's duty by its difference from the average
module vr_startup_protect import vr_pkg::*; #(
  parameter int PG_DELAY = PG_DELAY_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic CHIP_ENABLE_IN,
  input wire logic DRIVER_SUPPLY_DETECT,
  input wire logic [MV_W-1:0] TARGET_REFERENCE,
  input wire logic [MV_W-1:0] FEEDBACK_SENSE,
  input wire logic [MV_W-1:0] FEEDBACK_RETURN,
  input wire logic [DUTY_W-1:0] DUTY_DEMAND,
  input wire logic [CS_W-1:0] SHARED_SENSE_AMP,
  output logic [2:0] SENSE_SELECT,
  output logic [MV_W-1:0] REF_OUT,
  input wire logic [NPH-1:0] PHASE_DRIVE_I,
  output logic [NPH-1:0] PHASE_DRIVE_O,
  output logic [NPH-1:0] PHASE_DRIVE_OE_N,
  input wire logic POWER_GOOD_I,
  output logic POWER_GOOD_O,
  output logic POWER_GOOD_OE_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic IRQ
);
  state_t state_r;
  state_t state_nxt;
  logic strap_done_r;
  logic [2:0] nphase_r;
  logic [6:0] cnt_r;
  logic [$clog2(SS_TICK_CYCLES)-1:0] tick_cnt_r;
  logic [$clog2(PG_DELAY+1)-1:0] pg_cnt_r;
  logic pg_r;
  logic [NPH-1:0] drive_o_r;
  logic [NPH-1:0] drive_oe_n_r;
  logic [NPH-1:0] pwm_on;
  logic [NPH*DUTY_W-1:0] duty;
  logic [MV_W-1:0] ref_w;
  logic at_target;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [EV_W-1:0] ev_r;
  logic [EV_W-1:0] mask_r;
  logic [7:0] ss_step_r;

  // readiness: reset release shows as the finished strap capture
  wire ready = strap_done_r & CHIP_ENABLE_IN & DRIVER_SUPPLY_DETECT;
  wire running = (state_r == ST_RAMP) || (state_r == ST_RUN);
  wire [MV_W-1:0] fb_diff = (FEEDBACK_SENSE >= FEEDBACK_RETURN) ?
                            FEEDBACK_SENSE - FEEDBACK_RETURN : '0;
  wire [MV_W:0] ov_level = {1'b0, ref_w} + {1'b0, OV_MARGIN_MV};
  wire ov_hit = running && ({1'b0, fb_diff} > ov_level);
  wire pg_cond = (state_r == ST_RUN) && at_target && (fb_diff >= ref_w);
  wire pg_ok = pg_r && ready && (state_r == ST_RUN) && !ov_hit;
  wire tick = (tick_cnt_r == '0);
  wire sample = (cnt_r[3:0] == 4'hf);
  // strap decode, phase 3 has priority; a pulled-high phase 4 picks three
  wire [2:0] strap_n = PHASE_DRIVE_I[2] ? 3'h2 :
                       PHASE_DRIVE_I[4] ? 3'h4 :
                       PHASE_DRIVE_I[3] ? 3'h3 : NPH_RST;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_OFF: if (ready) state_nxt = ST_RAMP;
      ST_RAMP: begin
        if (!ready) state_nxt = ST_OFF;
        else if (ov_hit) state_nxt = ST_FAULT;
        else if (at_target) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (!ready) state_nxt = ST_OFF;
        else if (ov_hit) state_nxt = ST_FAULT;
      end
      ST_FAULT: if (!ready) state_nxt = ST_OFF;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // the drive pins float until this first capture, so the straps read cleanly
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      strap_done_r <= 1'b0;
      nphase_r <= NPH_RST;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      nphase_r <= strap_n;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_r <= '0;
      tick_cnt_r <= '0;
    end else begin
      cnt_r <= (cnt_r == 7'(PERIOD_CYCLES - 1)) ? '0 : cnt_r + 7'h01;
      tick_cnt_r <= tick ? ($bits(tick_cnt_r))'(SS_TICK_CYCLES - 1) : tick_cnt_r - 1'b1;
    end
  end

  soft_start_ramp u_ramp (
    .clk(SYS_CLK),
    .nrst(NRST),
    .run_i(running),
    .tick_i(tick),
    .step_i(ss_step_r),
    .target_i(TARGET_REFERENCE),
    .ref_o(ref_w),
    .at_target_o(at_target)
  );

  phase_balance u_bal (
    .clk(SYS_CLK),
    .nrst(NRST),
    .sample_i(sample),
    .slot_i(cnt_r[6:4]),
    .cs_i(SHARED_SENSE_AMP),
    .nphase_i(nphase_r),
    .base_i(DUTY_DEMAND),
    .duty_o(duty)
  );

  // one sense slot per phase, five slots per switching period
  assign SENSE_SELECT = cnt_r[6:4];
  assign REF_OUT = ref_w;

  genvar g;
  generate
    for (g = 0; g < NPH; g++) begin : gpwm
      wire [7:0] s = {1'b0, cnt_r} + {1'b0, phase_off(nphase_r, g)};
      wire [7:0] loc = (s >= 8'(PERIOD_CYCLES)) ? s - 8'(PERIOD_CYCLES) : s;
      assign pwm_on[g] = (loc < {1'b0, duty[g*DUTY_W +: DUTY_W]});
    end
  endgenerate

  wire [NPH-1:0] active;
  generate
    for (g = 0; g < NPH; g++) begin : gact
      assign active[g] = (3'(g) < nphase_r);
    end
  endgenerate

  // fault: drive low so the drivers pull the output down; off: float
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      drive_o_r <= '0;
      drive_oe_n_r <= '1;
    end else if (state_r == ST_FAULT) begin
      drive_o_r <= '0;
      drive_oe_n_r <= '0;
    end else if (running && ready) begin
      drive_o_r <= pwm_on & active;
      drive_oe_n_r <= ~active;
    end else begin
      drive_o_r <= '0;
      drive_oe_n_r <= '1;
    end
  end
  assign PHASE_DRIVE_O = drive_o_r;
  assign PHASE_DRIVE_OE_N = drive_oe_n_r;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      pg_cnt_r <= '0;
      pg_r <= 1'b0;
    end else if (!pg_cond) begin
      pg_cnt_r <= '0;
      pg_r <= pg_r && (state_r == ST_RUN) && ready;
    end else if (!pg_r) begin
      pg_cnt_r <= pg_cnt_r + 1'b1;
      pg_r <= (pg_cnt_r == ($bits(pg_cnt_r))'(PG_DELAY - 1));
    end
  end
  // open drain: enable low pulls the line low, high lets the resistor release it
  assign POWER_GOOD_O = 1'b0;
  assign POWER_GOOD_OE_N = pg_ok;

  // register bus: ack one cycle after the request, writes land at the ack edge
  wire req = WB_CYC_I & WB_STB_I;
  wire wr = req & WB_WE_I & ack_r & WB_SEL_I[0];
  wire wr_ev = wr && (WB_ADR_I == REG_EVENT);
  wire wr_mask = wr && (WB_ADR_I == REG_MASK);
  wire wr_step = wr && (WB_ADR_I == REG_SS_STEP);
  wire [EV_W-1:0] ev_set;
  assign ev_set[EV_OV] = ov_hit;
  assign ev_set[EV_PG] = pg_cond && !pg_r && (pg_cnt_r == ($bits(pg_cnt_r))'(PG_DELAY - 1));
  assign ev_set[EV_DROP] = running && !ready;
  wire [EV_W-1:0] ev_clr = wr_ev ? WB_DAT_I[EV_W-1:0] : '0;
  wire [31:0] status = {23'h000000, nphase_r, POWER_GOOD_I, pg_ok,
                        (state_r == ST_FAULT), ready, state_r};
  wire [31:0] rd_mux = (WB_ADR_I == REG_STATUS) ? status :
                       (WB_ADR_I == REG_EVENT) ? {29'h0, ev_r} :
                       (WB_ADR_I == REG_MASK) ? {29'h0, mask_r} :
                       (WB_ADR_I == REG_SS_STEP) ? {24'h000000, ss_step_r} : '0;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      ack_r <= req & ~ack_r;
      rdata_r <= (req & ~ack_r) ? rd_mux : '0;
    end
  end
  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = rdata_r;

  // a new event in the clearing cycle survives: set wins over clear
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ev_r <= '0;
      mask_r <= '0;
      ss_step_r <= SS_STEP_RST;
    end else begin
      ev_r <= (ev_r & ~ev_clr) | ev_set;
      if (wr_mask) mask_r <= WB_DAT_I[EV_W-1:0];
      if (wr_step) ss_step_r <= WB_DAT_I[7:0];
    end
  end
  assign IRQ = |(ev_r & mask_r);

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  a_start_gated: assert property (
    state_r == ST_OFF && !ready |=> state_r == ST_OFF)
    else $error("left off state without readiness");
  a_start_ramp: assert property (
    state_r == ST_OFF && ready |=> state_r == ST_RAMP)
    else $error("ramp did not start when ready");
  a_hiz_off: assert property (
    state_r == ST_OFF ##1 state_r == ST_OFF |-> PHASE_DRIVE_OE_N == '1)
    else $error("phase pins driven while not ready");
  a_ov_trip: assert property (
    ov_hit && ready |=> state_r == ST_FAULT ##1 PHASE_DRIVE_O == '0)
    else $error("over-voltage not latched");
  a_fault_low: assert property (
    state_r == ST_FAULT |=> PHASE_DRIVE_OE_N == '0 && PHASE_DRIVE_O == '0)
    else $error("phases not held low in fault");
  a_fault_hold: assert property (
    state_r == ST_FAULT && ready |=> state_r == ST_FAULT)
    else $error("fault latch cleared while ready");
  a_pg_drop: assert property (
    !ready || state_r == ST_FAULT |-> !POWER_GOOD_OE_N)
    else $error("power good released while not ready or faulted");
  a_pg_delay: assert property (
    $rose(POWER_GOOD_OE_N) |-> $past(pg_cond, 1) && $past(state_r == ST_RUN, 2))
    else $error("power good released without qualified delay");
  a_phase_hold: assert property (
    strap_done_r |=> $stable(nphase_r))
    else $error("phase count changed after capture");
  a_unused_float: assert property (
    running && ready && $past(running && ready) && nphase_r < 3'h5 |=> PHASE_DRIVE_OE_N[4])
    else $error("unselected phase driven");

  // bus handshake: one-cycle answer, data zero outside the answer
  a_ack_answer: assert property (
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not answered in one cycle");

  a_ack_pulse: assert property (
    WB_ACK_O |=> !WB_ACK_O)
    else $error("bus answer held longer than one cycle");

  a_dat_idle: assert property (
    !WB_ACK_O |-> WB_DAT_O == '0)
    else $error("read data shown outside an answer");

  a_ov_event: assert property (
    ov_hit |=> ev_r[EV_OV])
    else $error("over-voltage event not recorded");

  a_drop_event: assert property (
    running && !ready |=> ev_r[EV_DROP])
    else $error("readiness loss not recorded");

  a_pg_run_only: assert property (
    state_r != ST_RUN |-> !POWER_GOOD_OE_N)
    else $error("power good released outside regulation");

  a_ref_off: assert property (
    state_r == ST_OFF |=> REF_OUT == '0)
    else $error("reference not parked while off");

  a_ramp_done: assert property (
    state_r == ST_RAMP && ready && !ov_hit && at_target |=> state_r == ST_RUN)
    else $error("ramp did not hand over to regulation");

  a_drop_off: assert property (
    state_r != ST_OFF && !ready |=> state_r == ST_OFF)
    else $error("readiness loss did not stop the controller");

  a_strap_once: assert property (
    !strap_done_r |=> strap_done_r)
    else $error("strap capture not taken at first edge");

  a_sense_range: assert property (
    SENSE_SELECT < 3'h5)
    else $error("sense slot outside the phases");

  a_period_wrap: assert property (
    cnt_r == 7'(PERIOD_CYCLES - 1) |=> cnt_r == '0)
    else $error("switching period did not wrap");
endmodule

// File: logic/vr_pkg.sv
// constants and types of the phase start-up and protection block
package vr_pkg;
  localparam int CLK_MHZ = 25;
  localparam int MV_W = 12;
  localparam int CS_W = 10;
  localparam int NPH = 5;
  localparam int DUTY_W = 7;
  localparam int PERIOD_CYCLES = 80;
  localparam int SLOT_CYCLES = 16;
  localparam int MAX_ON_CYCLES = 40;
  localparam int BAL_SHIFT = 2;
  localparam logic [MV_W-1:0] OV_MARGIN_MV = 12'h0aa;
  localparam logic [MV_W-1:0] SS_DROP_MV = 12'h064;
  localparam int SS_TICK_US = 1;
  localparam int SS_TICK_CYCLES = SS_TICK_US * CLK_MHZ;
  localparam int PG_DELAY_US = 1500;
  localparam int PG_DELAY_CYCLES = PG_DELAY_US * CLK_MHZ;
  localparam logic [7:0] SS_STEP_RST = 8'h02;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_EVENT = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_SS_STEP = 8'h0c;
  localparam int EV_W = 3;
  localparam int EV_OV = 0;
  localparam int EV_PG = 1;
  localparam int EV_DROP = 2;
  localparam logic [2:0] NPH_RST = 3'h5;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RAMP = 2'b01,
    ST_RUN = 2'b11,
    ST_FAULT = 2'b10
  } state_t;
  // reciprocal of the phase count in 1/256 units, for the current average
  function automatic logic [7:0] recip(input logic [2:0] n);
    case (n)
      3'h2: recip = 8'h80;
      3'h3: recip = 8'h55;
      3'h4: recip = 8'h40;
      default: recip = 8'h33;
    endcase
  endfunction
  // switching start offset of phase i when n phases are active
  function automatic logic [6:0] phase_off(input logic [2:0] n, input int i);
    case (n)
      3'h2: phase_off = 7'(i * 40);
      3'h3: phase_off = 7'((i * 80) / 3);
      3'h4: phase_off = 7'(i * 20);
      default: phase_off = 7'(i * 16);
    endcase
  endfunction
endpackage

// File: logic/soft_start_ramp.sv
// soft-start ramp that moves the regulation reference toward the target
`timescale 1ns/1ps
module soft_start_ramp import vr_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [7:0] step_i,
  input wire logic [MV_W-1:0] target_i,
  output logic [MV_W-1:0] ref_o,
  output logic at_target_o
);
  logic [MV_W:0] ss_r;
  logic [MV_W:0] ss_nxt;
  wire [MV_W:0] goal = {1'b0, target_i} + {1'b0, SS_DROP_MV};
  wire [MV_W:0] stp = {5'h00, step_i};
  wire [MV_W:0] up = ss_r + stp;
  wire [MV_W:0] drop = {1'b0, SS_DROP_MV};
  // flat until the drop is covered, then linear: reference trails by the drop
  assign ref_o = (ss_r > drop) ? MV_W'(ss_r - drop) : '0;
  assign at_target_o = (ss_r == goal);
  // the same ramp also serves target changes, so moves are never abrupt
  assign ss_nxt = (ss_r < goal) ? ((up >= goal) ? goal : up) :
                  (ss_r >= goal + stp) ? ss_r - stp : goal;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ss_r <= '0;
    end else if (!run_i) begin
      ss_r <= '0;
    end else if (tick_i) begin
      ss_r <= ss_nxt;
    end
  end
  a_ramp_gradual: assert property (@(posedge clk) disable iff (!nrst)
    run_i && $past(run_i) |->
    (ss_r <= $past(ss_r) + $past(stp)) && (ss_r + $past(stp) >= $past(ss_r)))
    else $error("soft-start ramp moved by more than one step");
endmodule

// File: logic/phase_balance.sv
// held phase currents, their average and per-phase duty trim
`timescale 1ns/1ps
module phase_balance import vr_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sample_i,
  input wire logic [2:0] slot_i,
  input wire logic [CS_W-1:0] cs_i,
  input wire logic [2:0] nphase_i,
  input wire logic [DUTY_W-1:0] base_i,
  output logic [NPH*DUTY_W-1:0] duty_o
);
  logic [CS_W-1:0] held_w [NPH];
  logic [CS_W+2:0] sum;
  wire [CS_W+10:0] prod = {8'h00, sum} * {{(CS_W+3){1'b0}}, recip(nphase_i)};
  wire [CS_W-1:0] avg = prod[CS_W+7:8];
  always_comb begin
    sum = '0;
    for (int i = 0; i < NPH; i++) begin
      if (i < int'(nphase_i)) begin
        sum = sum + {3'h0, held_w[i]};
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < NPH; g++) begin : gph
      // one process per phase owns its held sample and its duty, so no shared driver
      logic [CS_W-1:0] held_r;
      logic [DUTY_W-1:0] duty_r;
      wire signed [CS_W:0] diff = $signed({1'b0, avg}) - $signed({1'b0, held_r});
      wire signed [CS_W+1:0] adj = $signed({1'b0, base_i}) + (diff >>> BAL_SHIFT);
      // below average lengthens, above shortens, limited to the on-time ceiling
      wire [DUTY_W-1:0] dut = adj[CS_W+1] ? '0 :
        (adj > MAX_ON_CYCLES) ? DUTY_W'(MAX_ON_CYCLES) : DUTY_W'(adj);
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          held_r <= '0;
          duty_r <= '0;
        end else begin
          if (sample_i && slot_i == 3'(g)) begin
            held_r <= cs_i;
          end
          duty_r <= dut;
        end
      end
      assign held_w[g] = held_r;
      assign duty_o[g*DUTY_W +: DUTY_W] = duty_r;
    end
  endgenerate
endmodule

// File: testbench/vr_power_stage.sv
// gate driver and power stage model facing the phase pins
`timescale 1ns/1ps
module vr_power_stage import vr_pkg::*; (
  input wire logic [NPH-1:0] pull_up,
  input wire logic [NPH-1:0] drive_o,
  input wire logic [NPH-1:0] drive_oe_n,
  input wire logic [2:0] sense_sel,
  input wire logic [MV_W-1:0] ref_mv,
  input wire logic [MV_W-1:0] ov_bump,
  input wire logic pg_o,
  input wire logic pg_oe_n,
  output logic [NPH-1:0] pin,
  output logic [CS_W-1:0] sense,
  output logic [MV_W-1:0] fb_mv,
  output logic pg_pin
);
  // phase currents in sense units; phase 2 carries more so the trim has work to do
  localparam logic [CS_W-1:0] CUR [NPH] = '{10'h064, 10'h08c, 10'h078, 10'h078, 10'h078};
  // a released pin falls to the driver's pull-down unless the board strap pulls it up
  assign pin = (drive_o & ~drive_oe_n) | (pull_up & drive_oe_n);
  // an index outside the phases gives a pattern, never a stale value
  assign sense = (sense_sel < 3'h5) ? CUR[sense_sel] : 10'h2aa;
  // the stage tracks the reference at once; bump models an overshoot
  assign fb_mv = ref_mv + ov_bump;
  assign pg_pin = pg_oe_n ? 1'b1 : pg_o; // open drain, pulled up
endmodule

// File: testbench/testbench.sv
// self-checking bench of the start-up, protection and balance block
`timescale 1ns/1ps
module testbench import vr_pkg::*;;
  localparam int PGD = 20;
  localparam int BASE = 20;
  localparam int I0 = 100;
  localparam int I1 = 140;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b0;
  logic driver_supply_detect = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [MV_W-1:0] tgt = 12'h000;
  logic [MV_W-1:0] bump = 12'h000;
  logic [NPH-1:0] straps = 5'h00;
  logic [MV_W-1:0] prev = 12'h000;
  logic mon_on = 1'b0;
  logic mon_sense = 1'b0;
  logic [7:0] seen = 8'h00;
  logic [31:0] rdat, d;
  logic ack, irq, pg_o, pg_oe, pg_i;
  logic [NPH-1:0] pdo, pdoe, pdi;
  logic [2:0] sns_sel;
  logic [CS_W-1:0] sns;
  logic [MV_W-1:0] ref_mv, fb;
  logic [NPH-1:0] pu_tab [4] = '{5'h00, 5'h08, 5'h10, 5'h04};
  logic [2:0] np_tab [4] = '{3'h5, 3'h3, 3'h4, 3'h2};
  int num_errors = 0;
  int n_compared = 0;
  int n, h;
  vr_startup_protect #(.PG_DELAY(PGD)) dut (.SYS_CLK(clk), .NRST(nrst), .CHIP_ENABLE_IN(ce),
    .DRIVER_SUPPLY_DETECT(driver_supply_detect), .TARGET_REFERENCE(tgt), .FEEDBACK_SENSE(fb),
    .FEEDBACK_RETURN(12'h000), .DUTY_DEMAND(7'(BASE)), .SHARED_SENSE_AMP(sns),
    .SENSE_SELECT(sns_sel), .REF_OUT(ref_mv), .PHASE_DRIVE_I(pdi), .PHASE_DRIVE_O(pdo),
    .PHASE_DRIVE_OE_N(pdoe), .POWER_GOOD_I(pg_i), .POWER_GOOD_O(pg_o),
    .POWER_GOOD_OE_N(pg_oe), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ(irq));
  vr_power_stage stage (.pull_up(straps), .drive_o(pdo), .drive_oe_n(pdoe),
    .sense_sel(sns_sel), .ref_mv(ref_mv), .ov_bump(bump), .pg_o(pg_o), .pg_oe_n(pg_oe),
    .pin(pdi), .sense(sns), .fb_mv(fb), .pg_pin(pg_i));
  initial begin
    forever #20 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("mismatches %0d, comparisons %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one classic cycle; request held until ack is seen at a rising edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] dw, output logic [31:0] dr);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dw;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    dr = rdat;
    chk(32'(ack), 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] dw);
    logic [31:0] x;
    wb(1'b1, a, dw, x);
    // the write lands at the ack edge; let it settle before anything looks at it
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] dr);
    wb(1'b0, a, 32'h0, dr);
  endtask
  task do_reset(input logic [NPH-1:0] pu);
    @(posedge clk);
    nrst <= 1'b0;
    straps <= pu;
    ce <= 1'b0;
    driver_supply_detect <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(pdoe), 32'h1f);
    chk(32'({pg_oe, irq}), 32'h0);
    nrst <= 1'b1;
    @(posedge clk);
  endtask
  task wait_ref(input logic [MV_W-1:0] v);
    n = 0;
    while (ref_mv !== v && n < 8000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(ref_mv), 32'(v));
  endtask
  // the reference may only creep, one programmed step at a time
  always @(posedge clk) begin
    prev <= ref_mv;
    if (mon_sense) seen[sns_sel] <= 1'b1;
    if (mon_on) chk(32'((ref_mv >= prev) ? (ref_mv - prev <= 12'h010) :
      (prev - ref_mv <= 12'h010)), 32'h1);
  end
  initial begin
    #(40 * 60000);
    num_errors++;
    complete_run();
  end
  initial begin
    for (int k = 0; k < 4; k++) begin
      do_reset(pu_tab[k]);
      rd(REG_STATUS, d);
      chk(32'(d[8:6]), 32'(np_tab[k]));
    end
    rd(REG_MASK, d);
    chk(d, 32'h0);
    rd(REG_SS_STEP, d);
    chk(d, 32'(SS_STEP_RST));
    rd(REG_EVENT, d);
    chk(d, 32'h0);
    wr(8'h10, 32'hffffffff);
    rd(8'h10, d);
    chk(d, 32'h0);
    for (int k = 0; k < 2; k++) begin
      ce <= k[0];
      driver_supply_detect <= ~k[0];
      repeat (10) @(posedge clk);
      chk(32'(pdoe), 32'h1f);
      rd(REG_STATUS, d);
      chk(32'(d[1:0]), 32'h0);
    end
    wr(REG_SS_STEP, 32'h10);
    wr(REG_MASK, 32'h7);
    tgt <= 12'h3e8;
    mon_on <= 1'b1;
    ce <= 1'b1; // system power logic enables the controller
    driver_supply_detect <= 1'b1;
    rd(REG_STATUS, d);
    chk(32'(d[1:0]), 32'h1);
    wait_ref(12'h3e8);
    n = 0;
    while (pg_oe !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n >= PGD && n <= PGD + 40), 32'h1);
    chk(32'({pg_i, irq}), 32'h3);
    rd(REG_EVENT, d);
    chk(d, 32'h2);
    wr(REG_EVENT, 32'h2);
    chk(32'(irq), 32'h0);
    chk(32'(pdoe), 32'h1c);
    straps <= 5'h10;
    rd(REG_STATUS, d);
    chk(32'(d[8:6]), 32'h2);
    mon_sense <= 1'b1;
    repeat (800) @(posedge clk);
    h = 0;
    repeat (PERIOD_CYCLES) begin
      @(posedge clk);
      h += pdo[0];
    end
    chk(32'(h), 32'(BASE + ((I0 + I1) / 2 - I0) / 4));
    h = 0;
    repeat (PERIOD_CYCLES) begin
      @(posedge clk);
      h += pdo[1];
    end
    chk(32'(h), 32'(BASE - (I1 - (I0 + I1) / 2) / 4));
    chk(32'(seen[1:0]), 32'h3);
    tgt <= 12'h4b0;
    wait_ref(12'h4b0);
    mon_on <= 1'b0;
    bump <= 12'h0aa;
    repeat (50) @(posedge clk);
    rd(REG_STATUS, d);
    chk(32'(d[3:0]), 32'h7);
    bump <= 12'h0ab;
    n = 0;
    while (pdoe !== 5'h00 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(32'({pdoe, pdo}), 32'h0);
    chk(32'({pg_oe, irq}), 32'h1);
    bump <= 12'h000;
    repeat (50) @(posedge clk);
    rd(REG_STATUS, d);
    chk(32'(d[3:0]), 32'he);
    wr(REG_EVENT, 32'h7);
    chk(32'(irq), 32'h0);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    rd(REG_STATUS, d);
    chk(32'(d[3:0]), 32'h5);
    wait_ref(12'h4b0);
    n = 0;
    while (pg_oe !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    driver_supply_detect <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'({pg_oe, pdoe}), 32'h1f);
    rd(REG_EVENT, d);
    chk(32'(d[2]), 32'h1);
    complete_run();
  end
endmodule
